// ===== pkg/etrg_pkg.sv
// Shared constants for the event timer and receive guard block.
package etrg_pkg;

	// Register byte addresses on the APB bus.
	localparam logic [7:0] ADDR_TIMER_CONFIG = 8'h10;
	localparam logic [7:0] ADDR_GUARD_CONFIG = 8'h14;
	localparam logic [7:0] ADDR_TIMER_PRESET = 8'h18;
	localparam logic [7:0] ADDR_TIMER_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_GUARD_STATUS = 8'h20;

	// Reset values of the writable registers.
	localparam logic [13:0] TIMER_CONFIG_RESET = 14'h0000;
	localparam logic [27:0] GUARD_CONFIG_RESET = 28'h0000000;
	localparam logic [19:0] TIMER_PRESET_RESET = 20'h00000;

	// Field positions in the second timer configuration register.
	localparam int GO_RECEIVE_END_BIT = 13;
	localparam int GO_TRANSMIT_BEGIN_BIT = 12;
	localparam int GO_TRANSMIT_END_BIT = 11;
	localparam int GO_EXT_FIELD_ON_BIT = 10;
	localparam int GO_EXT_FIELD_OFF_BIT = 9;
	localparam int GO_OWN_FIELD_ON_BIT = 8;
	localparam int GO_OWN_FIELD_OFF_BIT = 7;
	localparam int GO_IMMEDIATELY_BIT = 6;
	localparam int RATE_SELECT_MSB = 5;
	localparam int RATE_SELECT_LSB = 3;
	localparam int CLOCK_MODE_BIT = 2;
	localparam int AUTO_RELOAD_BIT = 1;
	localparam int TIMER_ON_BIT = 0;
	localparam int TIMER_CONFIG_WIDTH = 14;

	// Field positions in the receive guard configuration register.
	localparam int GUARD_VALUE_MSB = 27;
	localparam int GUARD_VALUE_LSB = 8;
	localparam int GUARD_PRESCALER_MSB = 7;
	localparam int GUARD_PRESCALER_LSB = 0;
	localparam int GUARD_CONFIG_WIDTH = 28;

	// Status register layout.
	localparam int STATUS_ACTIVE_BIT = 20;

	// Counter widths.
	localparam int TIMER_WIDTH = 20;
	localparam int DIVIDER_WIDTH = 8;

	// Rates in kHz; the interface tick is made from the system clock by a
	// fractional accumulator that adds the interface rate each cycle.
	localparam int SYS_CLOCK_KHZ = 50000;
	localparam int IFACE_CLOCK_KHZ = 13560;
	localparam int ACC_WIDTH = 17;
	localparam logic [16:0] ACC_STEP = 17'(IFACE_CLOCK_KHZ);
	localparam logic [16:0] ACC_MODULUS = 17'(SYS_CLOCK_KHZ);

endpackage

// ===== rtl/etrg_tick_gen.sv
// Interface clock tick and prescaled rate tick generator.
`timescale 1ns/1ps
module etrg_tick_gen (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Rate selection.
	input wire logic [2:0] rate_select,
	// Tick outputs.
	output logic iface_tick,
	output logic rate_tick
);

	typedef struct packed {
		logic [16:0] acc;
		logic [7:0] div;
		logic iface_tick;
		logic rate_tick;
	} etrg_tick_type;

	etrg_tick_type s;
	etrg_tick_type next_s;

	// Mask of the divider bits that must all be one for a rate tick.
	function automatic logic [7:0] rate_mask(input logic [2:0] sel);
		logic [8:0] m;
		m = (9'h001 << (4'(sel) + 4'h1)) - 9'h001;
		return m[7:0];
	endfunction

	// Accumulate the interface rate; each overflow of the modulus is one tick,
	// so the long-run tick rate is exact although single gaps jitter by a cycle.
	always_comb begin
		logic [16:0] sum;
		sum = s.acc + etrg_pkg::ACC_STEP;
		next_s = s;
		next_s.iface_tick = 1'b0;
		next_s.rate_tick = 1'b0;
		if (sum >= etrg_pkg::ACC_MODULUS) begin
			next_s.acc = sum - etrg_pkg::ACC_MODULUS;
			next_s.iface_tick = 1'b1;
			next_s.div = s.div + 8'h01;
			if ((s.div | ~rate_mask(rate_select)) == 8'hff) begin
				next_s.rate_tick = 1'b1;
			end
		end else begin
			next_s.acc = sum;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign iface_tick = s.iface_tick;
	assign rate_tick = s.rate_tick;

endmodule

// ===== rtl/etrg_event_timer.sv
// Event-started down-counting timer and receive guard timer with APB registers.
`timescale 1ns/1ps
module etrg_event_timer (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Contactless front end events, one-cycle pulses.
	input wire logic receive_end,
	input wire logic transmit_begin,
	input wire logic transmit_end,
	input wire logic external_field_on,
	input wire logic external_field_off,
	input wire logic own_field_on,
	input wire logic own_field_off,
	// Received data strobe and its gated copy.
	input wire logic rx_data_valid,
	output logic rx_data_accept,
	// Timer and guard state.
	output logic second_timer_running,
	output logic second_timer_expired,
	output logic rx_guard_active
);

	typedef struct packed {
		logic [13:0] timer_config;
		logic [27:0] guard_config;
		logic [19:0] timer_preset;
		logic [19:0] timer_count;
		logic running;
		logic expired;
		logic [7:0] guard_prescale;
		logic [19:0] guard_count;
		logic guard_active;
		logic rx_accept;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} etrg_state_type;

	etrg_state_type s;
	etrg_state_type next_s;

	logic iface_tick;
	logic rate_tick;
	logic count_tick;
	logic [6:0] event_vector;
	logic start_hit;
	logic go_now;
	logic access;
	logic write_taken;
	logic config_write;
	logic [13:0] written_config;
	logic [19:0] guard_reload;
	logic [7:0] guard_prescaler;

	// Tells whether an APB address hits one of the mapped registers.
	function automatic logic is_mapped(input logic [7:0] addr);
		return addr == etrg_pkg::ADDR_TIMER_CONFIG || addr == etrg_pkg::ADDR_GUARD_CONFIG
			|| addr == etrg_pkg::ADDR_TIMER_PRESET || addr == etrg_pkg::ADDR_TIMER_STATUS
			|| addr == etrg_pkg::ADDR_GUARD_STATUS;
	endfunction

	// The tick generator follows the rate select held in the configuration.
	etrg_tick_gen u_tick_gen (
		.clk(clk),
		.rst(rst),
		.rate_select(s.timer_config[etrg_pkg::RATE_SELECT_MSB:etrg_pkg::RATE_SELECT_LSB]),
		.iface_tick(iface_tick),
		.rate_tick(rate_tick)
	);

	// Counting rate: raw interface ticks or the prescaled ticks.
	assign count_tick = s.timer_config[etrg_pkg::CLOCK_MODE_BIT] ? rate_tick : iface_tick;

	// Lowest start flag; the event vector is lined up with the start flags above it.
	localparam int EVENT_LSB = etrg_pkg::GO_OWN_FIELD_OFF_BIT;

	// Event vector lined up with the start flags, receive end at the top.
	assign event_vector[etrg_pkg::GO_RECEIVE_END_BIT - EVENT_LSB] = receive_end;
	assign event_vector[etrg_pkg::GO_TRANSMIT_BEGIN_BIT - EVENT_LSB] = transmit_begin;
	assign event_vector[etrg_pkg::GO_TRANSMIT_END_BIT - EVENT_LSB] = transmit_end;
	assign event_vector[etrg_pkg::GO_EXT_FIELD_ON_BIT - EVENT_LSB] = external_field_on;
	assign event_vector[etrg_pkg::GO_EXT_FIELD_OFF_BIT - EVENT_LSB] = external_field_off;
	assign event_vector[etrg_pkg::GO_OWN_FIELD_ON_BIT - EVENT_LSB] = own_field_on;
	assign event_vector[etrg_pkg::GO_OWN_FIELD_OFF_BIT - EVENT_LSB] = own_field_off;

	// Any enabled event may start the timer; whichever comes first wins.
	assign start_hit =
		|(event_vector & s.timer_config[etrg_pkg::GO_RECEIVE_END_BIT:EVENT_LSB]);

	// APB access phase; the write lands on the edge where pready is seen high.
	assign access = psel && penable;
	assign write_taken = access && pwrite && s.pready && is_mapped(paddr);
	assign written_config = pwdata[etrg_pkg::TIMER_CONFIG_WIDTH-1:0];

	// A landed write to the timer configuration; the immediate start and the
	// switch-off below both key on it.
	assign config_write = write_taken && paddr == etrg_pkg::ADDR_TIMER_CONFIG;

	// A write that sets both the on bit and the immediate flag starts the timer.
	assign go_now = config_write && written_config[etrg_pkg::TIMER_ON_BIT]
		&& written_config[etrg_pkg::GO_IMMEDIATELY_BIT];

	// Guard fields as currently configured.
	assign guard_reload = s.guard_config[etrg_pkg::GUARD_VALUE_MSB:etrg_pkg::GUARD_VALUE_LSB];
	assign guard_prescaler =
		s.guard_config[etrg_pkg::GUARD_PRESCALER_MSB:etrg_pkg::GUARD_PRESCALER_LSB];

	// Next state of registers, timer, guard and bus answer.
	always_comb begin
		next_s = s;
		next_s.expired = 1'b0;
		next_s.rx_accept = 1'b0;

		// Bus answer: one wait cycle, then pready with data or an error flag.
		next_s.pready = access && !s.pready;
		next_s.pslverr = 1'b0;
		if (access && !s.pready) begin
			next_s.pslverr = !is_mapped(paddr);
			next_s.prdata = 32'h00000000;
			if (!pwrite) begin
				unique case (paddr)
					etrg_pkg::ADDR_TIMER_CONFIG: begin
						next_s.prdata = {18'h00000, s.timer_config};
					end
					etrg_pkg::ADDR_GUARD_CONFIG: begin
						next_s.prdata = {4'h0, s.guard_config};
					end
					etrg_pkg::ADDR_TIMER_PRESET: begin
						next_s.prdata = {12'h000, s.timer_preset};
					end
					etrg_pkg::ADDR_TIMER_STATUS: begin
						next_s.prdata = {11'h000, s.running, s.timer_count};
					end
					etrg_pkg::ADDR_GUARD_STATUS: begin
						next_s.prdata = {11'h000, s.guard_active, s.guard_count};
					end
					default: begin
						next_s.prdata = 32'h00000000;
					end
				endcase
			end
		end

		// Register writes; bits beyond the implemented fields are dropped.
		if (write_taken) begin
			unique case (paddr)
				etrg_pkg::ADDR_TIMER_CONFIG: begin
					next_s.timer_config = written_config;
				end
				etrg_pkg::ADDR_GUARD_CONFIG: begin
					next_s.guard_config = pwdata[etrg_pkg::GUARD_CONFIG_WIDTH-1:0];
				end
				etrg_pkg::ADDR_TIMER_PRESET: begin
					next_s.timer_preset = pwdata[etrg_pkg::TIMER_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end

		// Second timer. An idle timer loads its preset on a start; a running one
		// ignores further events so the earliest event governs. The immediate flag
		// acts on the very write that sets the on bit, since the stored on bit is
		// still the old one in that cycle and would otherwise swallow the start.
		if (!s.running) begin
			if ((s.timer_config[etrg_pkg::TIMER_ON_BIT] && start_hit) || go_now) begin
				next_s.running = 1'b1;
				next_s.timer_count = s.timer_preset;
			end
		end else if (!s.timer_config[etrg_pkg::TIMER_ON_BIT]) begin
			next_s.running = 1'b0;
		end else if (count_tick) begin
			if (s.timer_count <= 20'h00001) begin
				next_s.expired = 1'b1;
				if (s.timer_config[etrg_pkg::AUTO_RELOAD_BIT]) begin
					next_s.timer_count = s.timer_preset;
				end else begin
					next_s.timer_count = 20'h00000;
					next_s.running = 1'b0;
				end
			end else begin
				next_s.timer_count = s.timer_count - 20'h00001;
			end
		end

		// A write that switches the timer off wins over any start in that cycle.
		if (config_write && !written_config[etrg_pkg::TIMER_ON_BIT]) begin
			next_s.running = 1'b0;
		end

		// Receive guard: armed at the end of each transmission unless the
		// reload value is zero, which turns the guard time off altogether.
		if (transmit_end) begin
			if (guard_reload != 20'h00000) begin
				next_s.guard_active = 1'b1;
				next_s.guard_count = guard_reload;
				next_s.guard_prescale = guard_prescaler;
			end else begin
				next_s.guard_active = 1'b0;
				next_s.guard_count = 20'h00000;
			end
		end else if (s.guard_active && iface_tick) begin
			if (s.guard_prescale == 8'h00) begin
				next_s.guard_prescale = guard_prescaler;
				next_s.guard_count = s.guard_count - 20'h00001;
				if (s.guard_count == 20'h00001) begin
					next_s.guard_active = 1'b0;
				end
			end else begin
				next_s.guard_prescale = s.guard_prescale - 8'h01;
			end
		end

		// Received data are passed on only outside the guard time.
		next_s.rx_accept = rx_data_valid && !s.guard_active;
	end

	// State register; every configuration field clears to zero on reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.timer_config <= etrg_pkg::TIMER_CONFIG_RESET;
			s.guard_config <= etrg_pkg::GUARD_CONFIG_RESET;
			s.timer_preset <= etrg_pkg::TIMER_PRESET_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register.
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign rx_data_accept = s.rx_accept;
	assign second_timer_running = s.running;
	assign second_timer_expired = s.expired;
	assign rx_guard_active = s.guard_active;

endmodule

// ===== tb/etrg_event_timer_asserts.sv
// Port-level checker for the event timer and receive guard block.
`timescale 1ns/1ps
module etrg_event_timer_asserts (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Front end events.
	input wire logic receive_end,
	input wire logic transmit_begin,
	input wire logic transmit_end,
	input wire logic external_field_on,
	input wire logic external_field_off,
	input wire logic own_field_on,
	input wire logic own_field_off,
	// Receive path and state.
	input wire logic rx_data_valid,
	input wire logic rx_data_accept,
	input wire logic second_timer_running,
	input wire logic second_timer_expired,
	input wire logic rx_guard_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Any front end event; the timer may only wake up on one of these or a config write.
	logic any_event;
	assign any_event = receive_end | transmit_begin | transmit_end | external_field_on
		| external_field_off | own_field_on | own_field_off;
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_cfg_write;
		pready && pwrite && paddr == 8'h10;
	endsequence
	a_apb_answer: assert property (s_access |=> pready)
		else $error("access not answered in one cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_err_unmapped: assert property (pready |-> pslverr == !(paddr inside {8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20})) else $error("slave error does not match address map");
	a_start_cause: assert property ($rose(second_timer_running) |-> $past(any_event)
		|| $past(pready && pwrite && paddr == 8'h10)) else $error("timer started alone");
	a_expire_running: assert property (second_timer_expired |-> $past(second_timer_running))
		else $error("expiry while idle");
	a_guard_arm: assert property ($rose(rx_guard_active) |-> $past(transmit_end))
		else $error("guard armed without transmit end");
	a_accept_cause: assert property (rx_data_accept |-> $past(rx_data_valid)
		&& !$past(rx_guard_active)) else $error("accept without open receive");
	a_guard_block: assert property (rx_guard_active && rx_data_valid |=> !rx_data_accept)
		else $error("receive accepted during guard");
	a_accept_open: assert property (!rx_guard_active && rx_data_valid |=> rx_data_accept)
		else $error("receive dropped while guard idle");
	c_cfg_write: cover property (s_cfg_write);
endmodule
bind etrg_event_timer etrg_event_timer_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .receive_end, .transmit_begin, .transmit_end,
	.external_field_on, .external_field_off, .own_field_on, .own_field_off, .rx_data_valid,
	.rx_data_accept, .second_timer_running, .second_timer_expired, .rx_guard_active);

// ===== tb/tb.sv
// Self-checking testbench for the event timer and receive guard block.
`timescale 1ns/1ps
module tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rx_data_valid = 0, rx_data_accept;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, running, expired, guard;
	logic [6:0] ev = 7'h00;
	int fail_count = 0, checks = 0, n, t0;
	typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic er;} etrg_row_type;
	etrg_row_type rows [5] = '{'{8'h10, 32'hffffffbe, 32'h00003fbe, 1'b0},
		'{8'h14, 32'hffffffff, 32'h0fffffff, 1'b0}, '{8'h18, 32'hffffffff, 32'h000fffff, 1'b0},
		'{8'h20, 32'hffffffff, 32'h00000000, 1'b0}, '{8'h24, 32'hffffffff, 32'h00000000, 1'b1}};
	etrg_event_timer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.receive_end(ev[6]), .transmit_begin(ev[5]), .transmit_end(ev[4]),
		.external_field_on(ev[3]), .external_field_off(ev[2]), .own_field_on(ev[1]),
		.own_field_off(ev[0]), .rx_data_valid(rx_data_valid), .rx_data_accept(rx_data_accept),
		.second_timer_running(running), .second_timer_expired(expired), .rx_guard_active(guard));
	// Free-running 50 MHz clock.
	always #10 clk = ~clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Measured cycle counts carry one cycle of tick jitter, so a tolerance is allowed.
	task chk_near(input int got, input int exp, input int tol);
		checks++;
		if (got <= exp - tol || got >= exp + tol) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer; the request is held until pready is seen at a rising edge.
	// Only the watchdog ends a wait that never gets an answer.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task pulse_ev(input int i);
		@(posedge clk);
		ev <= 7'(1 << i);
		@(posedge clk);
		ev <= 7'h00;
		#1;
	endtask
	// Counts cycles until a flag (0 expiry, 1 guard) reaches the wanted level.
	// Running out of the bound counts as a mismatch.
	task wait_for(input int sel, input logic lvl);
		for (n = 0; n < 3000 && (sel == 0 ? expired : guard) !== lvl; n++) @(posedge clk);
		if (n >= 3000) fail_count++;
		#1;
	endtask
	task tally_and_finish;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#(20 * 60000);
		fail_count++;
		tally_and_finish;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// Register table: write all ones (the timer configuration without its on and immediate bits), read back only the implemented fields.
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].wd);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].rd);
			chk(32'(er), 32'(rows[i].er));
			$display("test reg %h done", rows[i].a);
		end
		@(posedge clk);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int a = 8'h10; a <= 8'h18; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk(rd, 32'h0);
		end
		$display("test reset done");
		// Each start event: a foreign event is ignored, its own one starts a one-shot run.
		apb(1'b1, 8'h18, 32'h00000028);
		for (int i = 0; i < 7; i++) begin
			apb(1'b1, 8'h10, 32'h1 | (32'h80 << i));
			pulse_ev((i + 1) % 7);
			chk(32'(running), 32'h0);
			pulse_ev(i);
			chk(32'(running), 32'h1);
			wait_for(0, 1'b1);
			chk_near(n, 147, 5);
			@(posedge clk);
			#1;
			chk(32'(running), 32'h0);
			apb(1'b0, 8'h1c, 32'h0);
			chk(rd, 32'h0);
		end
		$display("test events done");
		// Immediate start with reload; expiry spacing follows each rate code.
		apb(1'b1, 8'h18, 32'h0);
		for (int s = -1; s < 8; s++) begin
			apb(1'b1, 8'h10, 32'h43 | (s >= 0 ? 32'h4 | 32'(s << 3) : 32'h0));
			#1;
			chk(32'(running), 32'h1);
			wait_for(0, 1'b1);
			@(posedge clk);
			wait_for(0, 1'b1);
			chk_near(n + 1, (2 << s) * 50000 / 13560 + (s < 0 ? 3 : 0), 3);
			chk(32'(running), 32'h1);
			apb(1'b1, 8'h10, 32'h0);
			#1;
			chk(32'(running), 32'h0);
		end
		$display("test rates done");
		// Guard time: prescaler 0x7F, value 2, then a zero value that disables it.
		apb(1'b1, 8'h14, 32'h0000027f);
		pulse_ev(4);
		chk(32'(guard), 32'h1);
		@(posedge clk);
		rx_data_valid <= 1'b1;
		@(posedge clk);
		rx_data_valid <= 1'b0;
		#1;
		chk(32'(rx_data_accept), 32'h0);
		wait_for(1, 1'b0);
		chk_near(n, 943, 6);
		@(posedge clk);
		rx_data_valid <= 1'b1;
		@(posedge clk);
		rx_data_valid <= 1'b0;
		#1;
		chk(32'(rx_data_accept), 32'h1);
		apb(1'b1, 8'h14, 32'h0000007f);
		pulse_ev(4);
		chk(32'(guard), 32'h0);
		$display("test guard done");
		tally_and_finish;
	end
endmodule
